// [verilog/crg_core.v]
// Processor core: programmer registers, addressing modes and pointer instructions
//
// Contract
// - Two byte accumulators, A high byte of D
// - Program counter addresses next instruction fetch
// - Stack pointer addresses next free stack byte
// - Flags N Z V C H; branches test N Z V C
// - Flag bit 4 masks maskable interrupts
// - Two top flag bits always read one
// - Immediate operand follows opcode, register width
// - Direct address high byte forced zero
// - Mode three direct misses internal registers
// - Extended address from bytes two and three
// - Indexed adds unsigned byte, index unchanged
// - Inherent ops single byte, no operand access
// - Taken branch adds signed displacement to PC
// - Copy stack to index gives SP+1, 3 cycles
// - Copy index to stack gives X-1, 3 cycles
// - Load stack pointer high then low byte
// - Push index low then high, four cycles
`timescale 1ns/1ps
`default_nettype none
`include "crg_defines.vh"

module crg_core
#(
  parameter [15:0] RST_VEC = `CRG_VEC_RST,
  parameter [15:0] IRQ_VEC = `CRG_VEC_IRQ,
  parameter [7:0] INT_TOP = `CRG_INT_TOP
)
(
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire mode3_i,
  input wire irq_i,
  input wire [7:0] mem_rdata_i,
  output reg [15:0] mem_addr_o,
  output reg [7:0] mem_wdata_o,
  output reg mem_rd_o,
  output reg mem_wr_o,
  output wire int_sel_o,
  output wire fetch_o,
  output wire irq_ack_o,
  output wire [7:0] acc_a_o,
  output wire [7:0] acc_b_o,
  output wire [15:0] acc_d_o,
  output wire [15:0] ix_o,
  output wire [15:0] sp_o,
  output wire [15:0] pc_o,
  output wire [7:0] ccr_o
);

  // ==========================================================
  // States
  localparam [3:0] S_FETCH = 4'h0;
  localparam [3:0] S_OPB1 = 4'h1;
  localparam [3:0] S_OPB2 = 4'h2;
  localparam [3:0] S_MEM1 = 4'h3;
  localparam [3:0] S_MEM2 = 4'h4;
  localparam [3:0] S_EXEC = 4'h5;
  localparam [3:0] S_WR1 = 4'h6;
  localparam [3:0] S_WR2 = 4'h7;
  localparam [3:0] S_PSH1 = 4'h8;
  localparam [3:0] S_PSH2 = 4'h9;
  localparam [3:0] S_PAD = 4'hA;
  localparam [3:0] S_VEC1 = 4'hB;
  localparam [3:0] S_VEC2 = 4'hC;

  // ==========================================================
  // Decode helpers
  function [2:0] crg_mode;
    input [7:0] op;
    begin
      if (op[7])
      begin
        case (op[5:4])
          2'h0: crg_mode = `CRG_M_IMM;
          2'h1: crg_mode = `CRG_M_DIR;
          2'h2: crg_mode = `CRG_M_IDX;
          default: crg_mode = `CRG_M_EXT;
        endcase
      end
      else if (op[7:4] == 4'h2)
        crg_mode = `CRG_M_REL;
      else
        crg_mode = `CRG_M_INH;
    end
  endfunction

  function crg_wide;
    input [7:0] op;
    begin
      crg_wide = (op[3:0] == `CRG_N_DBL) || (op[3:0] == `CRG_N_CMPX_LDD) || (op[3:0] == `CRG_N_STD) ||
        (op[3:0] == `CRG_N_LDSX) || (op[3:0] == `CRG_N_STSX);
    end
  endfunction

  function crg_store;
    input [7:0] op;
    begin
      crg_store = op[7] && (op[5:4] != 2'h0) &&
        ((op[3:0] == `CRG_N_STA) || (op[3:0] == `CRG_N_STD) || (op[3:0] == `CRG_N_STSX));
    end
  endfunction

  function crg_taken;
    input [3:0] cond;
    input [5:0] f;
    reg nv;
    reg t;
    begin
      nv = f[`CRG_CCR_N] ^ f[`CRG_CCR_V];
      case (cond[3:1])
        3'h0: t = 1'b1;
        3'h1: t = ~(f[`CRG_CCR_C] | f[`CRG_CCR_Z]);
        3'h2: t = ~f[`CRG_CCR_C];
        3'h3: t = ~f[`CRG_CCR_Z];
        3'h4: t = ~f[`CRG_CCR_V];
        3'h5: t = ~f[`CRG_CCR_N];
        3'h6: t = ~nv;
        default: t = ~(f[`CRG_CCR_Z] | nv);
      endcase
      crg_taken = t ^ cond[0]; // Odd codes test the opposite sense
    end
  endfunction

  function [15:0] crg_inc;
    input [15:0] v;
    begin
      crg_inc = v + 16'h0001;
    end
  endfunction

  function [15:0] crg_dec;
    input [15:0] v;
    begin
      crg_dec = v - 16'h0001;
    end
  endfunction

  // ==========================================================
  // State registers
  reg [3:0] state_q;
  reg [7:0] a_q;
  reg [7:0] b_q;
  reg [15:0] x_q;
  reg [15:0] sp_q;
  reg [15:0] pc_q;
  reg [5:0] ccr_q;
  reg [7:0] ir_q;
  reg [2:0] mode_q;
  reg [15:0] ea_q;
  reg [15:0] op_q;
  reg [15:0] wd_q;
  reg [15:0] vec_q;

  wire [3:0] nib = ir_q[3:0];
  wire wide = crg_wide(ir_q);
  wire store = crg_store(ir_q);
  wire irq_take = (state_q == S_FETCH) && irq_i && !ccr_q[`CRG_CCR_I];
  wire [15:0] d_val = {a_q, b_q};
  wire [7:0] acc_sel = ir_q[6] ? b_q : a_q;
  wire pad_op = (ir_q == `CRG_OP_COPY_SP_X) || (ir_q == `CRG_OP_COPY_X_SP) || (ir_q == `CRG_OP_INC_X) ||
    (ir_q == `CRG_OP_DEC_X) || (ir_q == `CRG_OP_INC_SP) || (ir_q == `CRG_OP_DEC_SP) ||
    (ir_q == `CRG_OP_ADD_B_X);
  wire mem_op = ir_q[7] && (mode_q != `CRG_M_INH);

  // ==========================================================
  // Arithmetic operand selection for memory-group instructions
  reg [15:0] alu_a;
  reg [15:0] alu_b;
  reg [1:0] alu_op;
  reg alu_upd;
  wire [15:0] alu_res;
  wire alu_n;
  wire alu_z;
  wire alu_v;
  wire alu_c;
  wire alu_h;

  always @*
  begin
    alu_a = 16'h0000;
    alu_b = op_q;
    alu_op = `CRG_ALU_PASS;
    alu_upd = 1'b1;
    case (nib)
      `CRG_N_SUB:
      begin
        alu_a = {8'h00, acc_sel};
        alu_op = `CRG_ALU_SUB;
      end
      `CRG_N_ADD:
      begin
        alu_a = {8'h00, acc_sel};
        alu_op = `CRG_ALU_ADD;
      end
      `CRG_N_DBL:
      begin
        alu_a = d_val;
        alu_op = ir_q[6] ? `CRG_ALU_ADD : `CRG_ALU_SUB;
      end
      `CRG_N_CMPX_LDD:
      begin
        alu_a = x_q;
        alu_op = ir_q[6] ? `CRG_ALU_PASS : `CRG_ALU_SUB;
      end
      `CRG_N_LDA: alu_op = `CRG_ALU_PASS;
      `CRG_N_STA: alu_b = {8'h00, acc_sel};
      `CRG_N_STD: alu_b = d_val;
      `CRG_N_LDSX: alu_op = `CRG_ALU_PASS;
      `CRG_N_STSX: alu_b = ir_q[6] ? x_q : sp_q;
      default: alu_upd = 1'b0; // Unsupported groups leave flags alone
    endcase
  end

  crg_alu u_alu
  (
    .a_i(alu_a),
    .b_i(alu_b),
    .op_i(alu_op),
    .wide_i(wide),
    .res_o(alu_res),
    .n_o(alu_n),
    .z_o(alu_z),
    .v_o(alu_v),
    .c_o(alu_c),
    .h_o(alu_h)
  );

  // ==========================================================
  // Bus drive; inherent execution cycles issue no strobe
  always @*
  begin
    mem_addr_o = pc_q;
    mem_wdata_o = wd_q[7:0];
    mem_rd_o = 1'b0;
    mem_wr_o = 1'b0;
    case (state_q)
      S_FETCH: mem_rd_o = ce_i && !irq_take;
      S_OPB1, S_OPB2: mem_rd_o = ce_i;
      S_MEM1:
      begin
        mem_addr_o = ea_q;
        mem_rd_o = ce_i;
      end
      S_MEM2:
      begin
        mem_addr_o = crg_inc(ea_q);
        mem_rd_o = ce_i;
      end
      S_WR1:
      begin
        mem_addr_o = ea_q;
        mem_wdata_o = wide ? wd_q[15:8] : wd_q[7:0];
        mem_wr_o = ce_i;
      end
      S_WR2:
      begin
        mem_addr_o = crg_inc(ea_q);
        mem_wr_o = ce_i;
      end
      S_PSH1:
      begin
        mem_addr_o = sp_q;
        mem_wdata_o = x_q[7:0];
        mem_wr_o = ce_i;
      end
      S_PSH2:
      begin
        mem_addr_o = sp_q;
        mem_wdata_o = x_q[15:8];
        mem_wr_o = ce_i;
      end
      S_VEC1:
      begin
        mem_addr_o = vec_q;
        mem_rd_o = ce_i;
      end
      S_VEC2:
      begin
        mem_addr_o = crg_inc(vec_q);
        mem_rd_o = ce_i;
      end
      default: mem_addr_o = pc_q;
    endcase
  end

  // Internal registers are not reachable through direct mode in mode three
  assign int_sel_o = (mem_rd_o || mem_wr_o) && (mem_addr_o[15:8] == 8'h00) && (mem_addr_o[7:0] <= INT_TOP) &&
    !(mode3_i && (mode_q == `CRG_M_DIR) && (state_q != S_FETCH) && (state_q != S_OPB1) &&
    (state_q != S_OPB2) && (state_q != S_VEC1) && (state_q != S_VEC2));

  // ==========================================================
  // Sequencer and register updates
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= S_VEC1;
      a_q <= 8'h00;
      b_q <= 8'h00;
      x_q <= 16'h0000;
      sp_q <= 16'h0000;
      pc_q <= 16'h0000;
      ccr_q <= `CRG_CCR_RST;
      ir_q <= `CRG_OP_NOP;
      mode_q <= `CRG_M_INH;
      ea_q <= 16'h0000;
      op_q <= 16'h0000;
      wd_q <= 16'h0000;
      vec_q <= RST_VEC;
    end
    else if (ce_i)
    begin
      case (state_q)
        S_FETCH:
        begin
          if (irq_take)
          begin
            // Stacking of registers is left to a wider core; only the vector is taken
            ccr_q[`CRG_CCR_I] <= 1'b1;
            vec_q <= IRQ_VEC;
            state_q <= S_VEC1;
          end
          else
          begin
            ir_q <= mem_rdata_i;
            mode_q <= crg_mode(mem_rdata_i);
            pc_q <= crg_inc(pc_q);
            state_q <= (crg_mode(mem_rdata_i) == `CRG_M_INH) ? S_EXEC : S_OPB1;
          end
        end
        S_OPB1:
        begin
          pc_q <= crg_inc(pc_q);
          case (mode_q)
            `CRG_M_IMM:
            begin
              if (wide)
              begin
                op_q[15:8] <= mem_rdata_i;
                state_q <= S_OPB2;
              end
              else
              begin
                op_q <= {8'h00, mem_rdata_i};
                state_q <= S_EXEC;
              end
            end
            `CRG_M_DIR:
            begin
              ea_q <= {8'h00, mem_rdata_i};
              state_q <= store ? S_EXEC : S_MEM1;
            end
            `CRG_M_IDX:
            begin
              ea_q <= x_q + {8'h00, mem_rdata_i};
              state_q <= store ? S_EXEC : S_MEM1;
            end
            `CRG_M_EXT:
            begin
              ea_q[15:8] <= mem_rdata_i;
              state_q <= S_OPB2;
            end
            default:
            begin
              op_q <= {{8{mem_rdata_i[7]}}, mem_rdata_i};
              state_q <= S_EXEC;
            end
          endcase
        end
        S_OPB2:
        begin
          pc_q <= crg_inc(pc_q);
          if (mode_q == `CRG_M_EXT)
          begin
            ea_q[7:0] <= mem_rdata_i;
            state_q <= store ? S_EXEC : S_MEM1;
          end
          else
          begin
            op_q[7:0] <= mem_rdata_i;
            state_q <= S_EXEC;
          end
        end
        S_MEM1:
        begin
          if (wide)
          begin
            op_q[15:8] <= mem_rdata_i;
            state_q <= S_MEM2;
          end
          else
          begin
            op_q <= {8'h00, mem_rdata_i};
            state_q <= S_EXEC;
          end
        end
        S_MEM2:
        begin
          op_q[7:0] <= mem_rdata_i;
          state_q <= S_EXEC;
        end
        S_EXEC:
        begin
          state_q <= S_FETCH;
          if (mode_q == `CRG_M_REL)
          begin
            if (crg_taken(ir_q[3:0], ccr_q))
              pc_q <= pc_q + op_q;
          end
          else if (mem_op)
          begin
            if (alu_upd)
            begin
              ccr_q[`CRG_CCR_N] <= alu_n;
              ccr_q[`CRG_CCR_Z] <= alu_z;
              ccr_q[`CRG_CCR_V] <= alu_v; // Pass operations clear overflow
            end
            if ((nib == `CRG_N_SUB) || (nib == `CRG_N_ADD) || (nib == `CRG_N_DBL) ||
              ((nib == `CRG_N_CMPX_LDD) && !ir_q[6]))
              ccr_q[`CRG_CCR_C] <= alu_c;
            if (nib == `CRG_N_ADD)
              ccr_q[`CRG_CCR_H] <= alu_h;
            if (store)
            begin
              wd_q <= alu_res;
              state_q <= S_WR1;
            end
            case (nib)
              `CRG_N_SUB, `CRG_N_ADD, `CRG_N_LDA:
              begin
                if (ir_q[6])
                  b_q <= alu_res[7:0];
                else
                  a_q <= alu_res[7:0];
              end
              `CRG_N_DBL:
              begin
                a_q <= alu_res[15:8];
                b_q <= alu_res[7:0];
              end
              `CRG_N_CMPX_LDD:
              begin
                if (ir_q[6])
                begin
                  a_q <= alu_res[15:8];
                  b_q <= alu_res[7:0];
                end
              end
              `CRG_N_LDSX:
              begin
                if (ir_q[6])
                  x_q <= alu_res;
                else
                  sp_q <= alu_res;
              end
              default: a_q <= a_q;
            endcase
          end
          else
          begin
            if (pad_op)
              state_q <= S_PAD;
            case (ir_q)
              `CRG_OP_COPY_SP_X: x_q <= crg_inc(sp_q);
              `CRG_OP_COPY_X_SP: sp_q <= crg_dec(x_q);
              `CRG_OP_INC_X:
              begin
                x_q <= crg_inc(x_q);
                ccr_q[`CRG_CCR_Z] <= (crg_inc(x_q) == 16'h0000);
              end
              `CRG_OP_DEC_X:
              begin
                x_q <= crg_dec(x_q);
                ccr_q[`CRG_CCR_Z] <= (crg_dec(x_q) == 16'h0000);
              end
              `CRG_OP_INC_SP: sp_q <= crg_inc(sp_q);
              `CRG_OP_DEC_SP: sp_q <= crg_dec(sp_q);
              `CRG_OP_ADD_B_X: x_q <= x_q + {8'h00, b_q};
              `CRG_OP_PUSH_X: state_q <= S_PSH1;
              `CRG_OP_CLR_V: ccr_q[`CRG_CCR_V] <= 1'b0;
              `CRG_OP_SET_V: ccr_q[`CRG_CCR_V] <= 1'b1;
              `CRG_OP_CLR_C: ccr_q[`CRG_CCR_C] <= 1'b0;
              `CRG_OP_SET_C: ccr_q[`CRG_CCR_C] <= 1'b1;
              `CRG_OP_CLR_I: ccr_q[`CRG_CCR_I] <= 1'b0;
              `CRG_OP_SET_I: ccr_q[`CRG_CCR_I] <= 1'b1;
              default: a_q <= a_q;
            endcase
          end
        end
        S_WR1: state_q <= wide ? S_WR2 : S_FETCH;
        S_WR2: state_q <= S_FETCH;
        S_PSH1:
        begin
          sp_q <= crg_dec(sp_q);
          state_q <= S_PSH2;
        end
        S_PSH2:
        begin
          sp_q <= crg_dec(sp_q);
          state_q <= S_FETCH;
        end
        S_PAD: state_q <= S_FETCH;
        S_VEC1:
        begin
          pc_q[15:8] <= mem_rdata_i;
          state_q <= S_VEC2;
        end
        S_VEC2:
        begin
          pc_q[7:0] <= mem_rdata_i;
          state_q <= S_FETCH;
        end
        default: state_q <= S_FETCH;
      endcase
    end
  end

  // ==========================================================
  // Visible register state
  assign fetch_o = (state_q == S_FETCH) && !irq_take;
  assign irq_ack_o = irq_take && ce_i;
  assign acc_a_o = a_q;
  assign acc_b_o = b_q;
  assign acc_d_o = d_val;
  assign ix_o = x_q;
  assign sp_o = sp_q;
  assign pc_o = pc_q;
  assign ccr_o = {`CRG_CCR_TOP, ccr_q};

endmodule // crg_core

`default_nettype wire

// [verilog/crg_defines.vh]
// Constants for the processor register and addressing-mode core
`ifndef CRG_DEFINES_VH
`define CRG_DEFINES_VH

// ==========================================================
// Condition code bit positions (two top bits read as one)
`define CRG_CCR_C 0
`define CRG_CCR_V 1
`define CRG_CCR_Z 2
`define CRG_CCR_N 3
`define CRG_CCR_I 4
`define CRG_CCR_H 5
`define CRG_CCR_RST 6'h10
`define CRG_CCR_TOP 2'h3

// ==========================================================
// Vectors and internal control register window
`define CRG_VEC_RST 16'hFFFE
`define CRG_VEC_IRQ 16'hFFF8
`define CRG_INT_TOP 8'h1F

// ==========================================================
// Addressing modes
`define CRG_M_INH 3'h0
`define CRG_M_IMM 3'h1
`define CRG_M_DIR 3'h2
`define CRG_M_IDX 3'h3
`define CRG_M_EXT 3'h4
`define CRG_M_REL 3'h5

// ==========================================================
// Inherent opcodes
`define CRG_OP_NOP 8'h01
`define CRG_OP_INC_X 8'h08
`define CRG_OP_DEC_X 8'h09
`define CRG_OP_CLR_V 8'h0A
`define CRG_OP_SET_V 8'h0B
`define CRG_OP_CLR_C 8'h0C
`define CRG_OP_SET_C 8'h0D
`define CRG_OP_CLR_I 8'h0E
`define CRG_OP_SET_I 8'h0F
`define CRG_OP_COPY_SP_X 8'h30
`define CRG_OP_INC_SP 8'h31
`define CRG_OP_DEC_SP 8'h34
`define CRG_OP_COPY_X_SP 8'h35
`define CRG_OP_ADD_B_X 8'h3A
`define CRG_OP_PUSH_X 8'h3C

// ==========================================================
// Low-nibble operation groups of memory opcodes (0x80..0xFF)
`define CRG_N_SUB 4'h0
`define CRG_N_DBL 4'h3
`define CRG_N_LDA 4'h6
`define CRG_N_STA 4'h7
`define CRG_N_ADD 4'hB
`define CRG_N_CMPX_LDD 4'hC
`define CRG_N_STD 4'hD
`define CRG_N_LDSX 4'hE
`define CRG_N_STSX 4'hF

// ==========================================================
// Arithmetic unit operations
`define CRG_ALU_PASS 2'h0
`define CRG_ALU_ADD 2'h1
`define CRG_ALU_SUB 2'h2

`endif

// [verilog/crg_alu.v]
// Arithmetic unit: 8/16-bit add, subtract and pass with condition flags
`timescale 1ns/1ps
`default_nettype none
`include "crg_defines.vh"

module crg_alu
(
  input wire [15:0] a_i,
  input wire [15:0] b_i,
  input wire [1:0] op_i,
  input wire wide_i,
  output reg [15:0] res_o,
  output reg n_o,
  output reg z_o,
  output reg v_o,
  output reg c_o,
  output reg h_o
);

  reg [16:0] s17;
  reg [8:0] s9;
  reg [4:0] s5;

  // ==========================================================
  // Result and flags
  always @*
  begin
    s17 = 17'h00000;
    s9 = 9'h000;
    s5 = 5'h00;
    res_o = 16'h0000;
    v_o = 1'b0;
    c_o = 1'b0;
    h_o = 1'b0;
    case (op_i)
      `CRG_ALU_ADD:
      begin
        s17 = {1'b0, a_i} + {1'b0, b_i};
        s9 = {1'b0, a_i[7:0]} + {1'b0, b_i[7:0]};
        s5 = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
        h_o = s5[4]; // Carry out of bit 3
        if (wide_i)
        begin
          res_o = s17[15:0];
          c_o = s17[16];
          v_o = (a_i[15] == b_i[15]) && (s17[15] != a_i[15]);
        end
        else
        begin
          res_o = {8'h00, s9[7:0]};
          c_o = s9[8];
          v_o = (a_i[7] == b_i[7]) && (s9[7] != a_i[7]);
        end
      end
      `CRG_ALU_SUB:
      begin
        s17 = {1'b0, a_i} - {1'b0, b_i};
        s9 = {1'b0, a_i[7:0]} - {1'b0, b_i[7:0]};
        if (wide_i)
        begin
          res_o = s17[15:0];
          c_o = s17[16]; // Borrow
          v_o = (a_i[15] != b_i[15]) && (s17[15] != a_i[15]);
        end
        else
        begin
          res_o = {8'h00, s9[7:0]};
          c_o = s9[8];
          v_o = (a_i[7] != b_i[7]) && (s9[7] != a_i[7]);
        end
      end
      default:
      begin
        res_o = wide_i ? b_i : {8'h00, b_i[7:0]};
      end
    endcase
    n_o = wide_i ? res_o[15] : res_o[7];
    z_o = wide_i ? (res_o == 16'h0000) : (res_o[7:0] == 8'h00);
  end

endmodule // crg_alu

`default_nettype wire

// [bench/crg_mem_model.sv]
// Byte memory that answers the core bus with no wait states
`timescale 1ns/1ps
`default_nettype none
// ====
// Memory array
module crg_mem_model
(
  input wire logic clk_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic rd_i,
  input wire logic wr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q = 8'h00;
  // Idle bus shows the inverse of the last byte so a stale sample is caught
  always_comb rdata_o = rd_i ? mem[addr_i] : ~last_q;
  // Writes land at the edge that ends the cycle
  always @(posedge clk_i)
  begin
    if (rd_i)
      last_q <= mem[addr_i];
    if (wr_i)
      mem[addr_i] <= wdata_i;
  end
endmodule // crg_mem_model
`default_nettype wire

// [bench/crg_core_properties.sv]
// Assertion checker for the processor core ports
`timescale 1ns/1ps
`default_nettype none
`include "crg_defines.vh"
// ====
// Port checker
module crg_core_checker
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic mode3_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic [15:0] mem_addr_o,
  input wire logic [7:0] mem_wdata_o,
  input wire logic mem_rd_o,
  input wire logic mem_wr_o,
  input wire logic int_sel_o,
  input wire logic fetch_o,
  input wire logic irq_ack_o,
  input wire logic [7:0] acc_a_o,
  input wire logic [7:0] acc_b_o,
  input wire logic [15:0] acc_d_o,
  input wire logic [15:0] ix_o,
  input wire logic [15:0] sp_o,
  input wire logic [7:0] ccr_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic dir_q;
  logic [7:0] lo_q;
  wire op_f = ce_i && fetch_o && mem_rd_o;
  // Last byte read, so operand bytes can be compared with the address later
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dir_q <= 1'b0;
      lo_q <= 8'h00;
    end
    else if (ce_i && mem_rd_o)
    begin
      lo_q <= mem_rdata_i;
      if (fetch_o)
        dir_q <= mem_rdata_i[7:4] == 4'h9;
    end
  end
  // ====
  // Properties; fixed delays assume the clock enable stays high
  acc_pair_a: assert property (acc_d_o == {acc_a_o, acc_b_o}) else $error("double not A:B");
  ccr_top_a: assert property (ccr_o[7:6] == 2'h3) else $error("flag top bits not one");
  irq_mask_a: assert property (irq_ack_o |-> !ccr_o[`CRG_CCR_I] ##1 ccr_o[`CRG_CCR_I])
    else $error("interrupt taken while masked");
  mode3_dir_a: assert property (dir_q && mode3_i && !fetch_o |-> !int_sel_o)
    else $error("direct access hit internal registers");
  dir_mode_a: assert property (op_f && mem_rdata_i[7:4] == 4'h9 ##1 ce_i |=> ##[0:1]
    (mem_rd_o || mem_wr_o) && mem_addr_o == {8'h00, lo_q}) else $error("direct address wrong");
  copy_sx_a: assert property (op_f && mem_rdata_i == `CRG_OP_COPY_SP_X |=> !mem_rd_o && !mem_wr_o ##1
    ix_o == $past(sp_o, 2) + 16'h1 && ccr_o == $past(ccr_o, 2) ##1 fetch_o) else $error("copy to index wrong");
  push_x_a: assert property (op_f && mem_rdata_i == `CRG_OP_PUSH_X |=> ##1 mem_wr_o &&
    mem_addr_o == $past(sp_o, 2) && mem_wdata_o == ix_o[7:0] ##1 mem_wr_o && mem_addr_o == $past(sp_o, 3) - 16'h1
    && mem_wdata_o == ix_o[15:8] ##1 fetch_o && sp_o == $past(sp_o, 4) - 16'h2) else $error("push index wrong");
  branch_rel_a: assert property (op_f && mem_rdata_i == 8'h20 ##1 ce_i |=> ##1 fetch_o && mem_addr_o ==
    $past(mem_addr_o, 3) + 16'h2 + {{8{$past(mem_rdata_i[7], 2)}}, $past(mem_rdata_i, 2)})
    else $error("branch target wrong");
endmodule // crg_core_checker

bind crg_core crg_core_checker chk_u (.*);
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking bench: runs a short program on the core against a model
`timescale 1ns/1ps
`default_nettype none
`include "crg_defines.vh"
// ====
// Bench top
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic mode3_i = 1'b1;
  logic irq_i = 1'b1;
  logic mem_rd_o, mem_wr_o, int_sel_o, fetch_o, irq_ack_o;
  logic [7:0] mem_rdata_i, mem_wdata_o, acc_a_o, acc_b_o, ccr_o;
  logic [15:0] mem_addr_o, acc_d_o, ix_o, sp_o, pc_o, mx, msp, md, pa;
  logic [7:0] mc;
  logic [71:0] q[$];
  logic [71:0] e;
  int checks = 0;
  int miscompares = 0;
  int cyc = 0;
  // Clock; design and memory
  always #50 clk_i = ~clk_i;
  crg_core DUT (.*);
  crg_mem_model mem_u (.clk_i(clk_i), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rd_i(mem_rd_o),
    .wr_i(mem_wr_o), .rdata_o(mem_rdata_i));
  // ====
  // Tasks
  task chk(input logic [15:0] seen, input logic [15:0] exp, input string name);
    checks = checks + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task end_of_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task put(input logic [7:0] b);
    mem_u.mem[pa] = b;
    pa = pa + 16'h1;
  endtask
  task put2(input logic [15:0] w);
    put(w[15:8]);
    put(w[7:0]);
  endtask
  task put3(input logic [23:0] v);
    put(v[23:16]);
    put2(v[15:0]);
  endtask
  // Model state at the next fetch, queued for the boundary monitor
  task ex(input logic [15:0] x, input logic [15:0] s, input logic [15:0] d, input logic [7:0] c);
    mx = x;
    msp = s;
    md = d;
    mc = c;
    q.push_back({pa, mx, msp, md, mc});
  endtask
  function automatic logic [7:0] nz(input logic [15:0] w);
    return (mc & 8'hF1) | {4'h0, w[15], w == 16'h0000, 2'h0};
  endfunction
  // ====
  // Boundary monitor and hang limit
  always @(posedge clk_i)
  begin
    cyc = cyc + 1;
    if (cyc == 1000)
    begin
      miscompares = miscompares + 1;
      end_of_test;
    end
    if (!rst_i && ce_i && fetch_o && !irq_ack_o && q.size() > 0)
    begin
      e = q.pop_front();
      chk(mem_addr_o, e[71:56], "fetch address");
      chk(ix_o, e[55:40], "index");
      chk(sp_o, e[39:24], "stack pointer");
      chk(acc_d_o, e[23:8], "double accumulator");
      chk({8'h00, ccr_o}, {8'h00, e[7:0]}, "flags");
      chk(pc_o, e[71:56], "program counter");
    end
    // Direct operand read of an internal register address: hidden only in mode three
    if (!rst_i && ce_i && mem_rd_o && mem_addr_o == 16'h0010)
      chk({15'h0000, int_sel_o}, {15'h0000, !mode3_i}, "internal select");
  end
  // ====
  // Program, stall and final memory checks
  initial
  begin
    logic [15:0] w0, w1, w2, w3;
    logic [7:0] off;
    void'($urandom(22079));
    w0 = 16'h5000 | (16'($urandom) & 16'h0FFF);
    w1 = 16'h6080 | (16'($urandom) & 16'h0F7F);
    w2 = 16'($urandom);
    w3 = 16'($urandom);
    off = 8'h80 | 8'($urandom);
    pa = `CRG_VEC_RST;
    put2(16'h0100);
    pa = `CRG_VEC_IRQ;
    put2(16'h0400);
    pa = 16'h2000;
    put2(w1);
    pa = w1 + {8'h00, off};
    put2(w2);
    pa = 16'h0010;
    put2(16'h0000);
    pa = 16'h0400;
    put3(24'h0120FE);
    pa = 16'h0100;
    ex(16'h0000, 16'h0000, 16'h0000, 8'hD0);
    // Direct load first with mode three on; the later one runs with it off
    put2(16'h9E10);
    ex(mx, 16'h0000, md, nz(16'h0000));
    put3({8'h8E, w0});
    ex(mx, w0, md, nz(w0));
    put(8'h30);
    ex(msp + 16'h1, msp, md, mc);
    put(8'h35);
    ex(mx, mx - 16'h1, md, mc);
    put3(24'hCE8000);
    ex(16'h8000, msp, md, nz(16'h8000));
    put(8'h3C);
    ex(mx, msp - 16'h2, md, mc);
    put3(24'hFE2000);
    ex(w1, msp, md, nz(w1));
    // Offset above 0x7F with a low byte above 0x7F forces a carry
    put2({8'hAE, off});
    ex(mx, w2, md, nz(w2));
    put3(24'hFF3000);
    ex(mx, msp, md, nz(mx));
    put3({8'hCC, w3});
    ex(mx, msp, w3, nz(w3));
    put2(16'h9E10);
    ex(mx, 16'h0000, md, nz(16'h0000));
    put3(24'h200200);
    put(8'h00);
    ex(mx, msp, md, mc);
    put2(16'h2B05);
    ex(mx, msp, md, mc);
    // Mask cleared with the request pending: next fetch comes from the vector
    put(8'h0E);
    pa = 16'h0400;
    ex(mx, msp, md, mc);
    pa = 16'h0401;
    ex(mx, msp, md, mc);
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wait (mem_addr_o == 16'h0114);
    @(posedge clk_i);
    ce_i <= 1'b0;
    mode3_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    ce_i <= 1'b1;
    while (q.size() > 0)
      @(posedge clk_i);
    repeat (4) @(posedge clk_i);
    chk({8'h00, mem_u.mem[w0]}, 16'h0000, "pushed low byte");
    chk({8'h00, mem_u.mem[w0 - 16'h1]}, 16'h0080, "pushed high byte");
    chk({mem_u.mem[16'h3000], mem_u.mem[16'h3001]}, w1, "stored index");
    end_of_test;
  end
endmodule // tb_top
`default_nettype wire
